// ===== hw/pcd_pkg.sv
// Constants, field layout and state type for the programmable clock divider.
package pcd_pkg;

  // ----------------------------------------------------------------------
  // Configuration word layout
  // ----------------------------------------------------------------------
  localparam int unsigned WORD_W       = 9;
  localparam int unsigned SHIFT_W      = 18;
  localparam int unsigned CNT_W        = 10;
  localparam int unsigned OSC_W        = 3;
  localparam int unsigned F_REF_SRC    = 0;
  localparam int unsigned F_DIV_BYP    = 1;
  localparam int unsigned F_PRE_BYP    = 2;
  localparam int unsigned F_PRE_RATIO  = 3;
  localparam int unsigned F_PIN_FN     = 4;
  localparam int unsigned F_REF_DIS    = 5;
  localparam int unsigned OSC_RAW_BIT  = 0;
  localparam int unsigned OSC_DIV2_BIT = 1;
  localparam int unsigned OSC_DIV4_BIT = 2;

  // ----------------------------------------------------------------------
  // Reset values and arithmetic constants
  // ----------------------------------------------------------------------
  localparam logic [8:0]  MODE_RST     = 9'h000;
  localparam logic [8:0]  DIV_RST      = 9'h000;
  localparam logic [8:0]  NV_MODE_DEF  = 9'h000;  // Arbitrary factory setting.
  localparam logic [8:0]  NV_DIV_DEF   = 9'h000;  // Arbitrary factory setting.
  localparam logic [9:0]  DIV_OFFSET   = 10'h002;
  localparam logic [9:0]  CNT_ONE      = 10'h001;
  localparam logic [9:0]  CNT_ZERO     = 10'h000;
  localparam logic [2:0]  OSC_ONE      = 3'h1;
  localparam logic [17:0] SHIFT_RST    = 18'h00000;

  typedef enum logic [2:0] {
    ST_BOOT, ST_PROG, ST_RUN, ST_STOP_DIV, ST_STOP_REF, ST_OFF
  } pcd_state_t;

endpackage : pcd_pkg

// ===== hw/pcd_top.sv
// Programmable clock divider: reference mux, prescaler, N divider, gating.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Output enable low stops output without truncation.
// - While disabled, oscillator runs, divider counter reset.
// - Restart: first edge within one-two master periods.
// - Power-down stops divided, then reference, then oscillator.
// - Power-down: both outputs high impedance, buffers off.
// - Select mode: pin high internal, low external.
// - Reference output ignores enable; glitch-free disable only.
// - Reference disable bit keeps reference output off.
// - Configuration changes only through programming then power-up.
// - Configuration is a mode word plus divisor word.
// - Mode word field order, top three bits zero.
// - Reference-source bit: one external, zero internal.
// - Power-down mode: pin low powers the device down.
// - Divider bypass routes master clock straight to output.
// - Bypass with internal reference also skips prescaler.
// - Prescale-bypass bit skips prescaler unless overridden.
// - Programming mode: divided pin shifts in configuration.
// - Operating power-up reloads stored values, pin outputs.
// - Prescale ratio zero divides by four, one two.
// - Divider divides by stored value plus two.
module pcd_top
  import pcd_pkg::*;
(
  input  wire logic CLK,
  input  wire logic RST,
  input  wire logic CE,
  input  wire logic OE_PIN,
  input  wire logic POWERDOWN_SELECT_PIN,
  input  wire logic EXT_REF_INPUT,
  input  wire logic PROG_MODE_PIN,
  input  wire logic DIV_IO_IN,
  input  wire logic SER_STROBE,
  input  wire logic WRITE_CMD,
  input  wire logic NV_FACTORY_RST,
  output logic      DIV_IO_OUT,
  output logic      DIV_IO_OE,
  output logic      REFERENCE_CLOCK_OUT,
  output logic      REFERENCE_CLOCK_OE,
  output logic      BUFFERS_ON
);
  import pcd_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Picks one field bit out of the mode word.
  function automatic logic mode_bit(input logic [8:0] w, input int unsigned pos);
    mode_bit = w[pos];
  endfunction : mode_bit

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  pcd_state_t        state_q, state_d;
  logic [8:0]        mode_q, div_q;
  logic [8:0]        nv_mode_q, nv_div_q;
  logic [17:0]       shift_q;
  logic [2:0]        osc_cnt_q;
  logic              sel_ext_q;
  logic              mclk_q;
  logic              oe_s_q;
  logic              run_q;
  logic [9:0]        cnt_q;
  logic              ref_on_q;
  logic              div_pin_q, div_oe_q, ref_pin_q, ref_oe_q, buf_q;

  // ----------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------
  // Fields of the loaded mode word; the top three bits are never decoded.
  wire pin_fn    = mode_bit(mode_q, F_PIN_FN);
  wire src_bit   = mode_bit(mode_q, F_REF_SRC);
  wire div_byp   = mode_bit(mode_q, F_DIV_BYP);
  wire pre_byp   = mode_bit(mode_q, F_PRE_BYP);
  wire pre_ratio = mode_bit(mode_q, F_PRE_RATIO);
  wire ref_dis   = mode_bit(mode_q, F_REF_DIS);
  wire pd_req    = pin_fn & ~POWERDOWN_SELECT_PIN;
  wire want_ext  = pin_fn ? src_bit : ~POWERDOWN_SELECT_PIN;
  wire osc_run   = (state_q == ST_RUN) || (state_q == ST_STOP_DIV) ||
                   (state_q == ST_STOP_REF);
  wire outs_live = osc_run;

  // ----------------------------------------------------------------------
  // Prescaler and reference mux
  // ----------------------------------------------------------------------
  // The internal oscillator is modelled by a free counter on CLK.
  wire raw_int  = osc_cnt_q[OSC_RAW_BIT];
  wire int_div  = pre_ratio ? osc_cnt_q[OSC_DIV2_BIT] : osc_cnt_q[OSC_DIV4_BIT];
  wire int_clk  = (pre_byp | div_byp) ? raw_int : int_div;
  wire cur_lvl  = sel_ext_q ? EXT_REF_INPUT : int_clk;
  wire nxt_lvl  = want_ext ? EXT_REF_INPUT : int_clk;
  // Switching only while both sources are low means no runt pulse at the mux.
  wire sw_ok    = (want_ext != sel_ext_q) & ~cur_lvl & ~nxt_lvl;
  wire mclk_d   = cur_lvl;
  wire mclk_rise = mclk_d & ~mclk_q;

  // ----------------------------------------------------------------------
  // N divider and output gating
  // ----------------------------------------------------------------------
  // Divisor is the stored value plus two; high while the count is below half the divisor, rounded down.
  wire [9:0] div_n    = {1'b0, div_q} + DIV_OFFSET;
  wire [9:0] half_n   = {1'b0, div_n[9:1]};
  wire       cnt_wrap = (cnt_q == (div_n - CNT_ONE));
  wire       div_raw  = div_byp ? mclk_q : (cnt_q < half_n);
  wire       run_set  = mclk_rise & oe_s_q;
  wire       run_clr  = ~oe_s_q & ~div_raw;
  wire       ref_want = outs_live & (state_q != ST_STOP_REF) & ~ref_dis;
  // Reference gate only changes while the master clock is low.
  wire       ref_gate = mclk_d ? ref_on_q : ref_want;

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // Boot decides programming or operating mode once after reset release.
  // The divided stop also waits for a low enable sample, or a sample taken
  // just before the request could restart the output behind the sequencer.
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_BOOT:     state_d = PROG_MODE_PIN ? ST_PROG : ST_RUN;
      ST_PROG:     state_d = ST_PROG;
      ST_RUN:      if (pd_req) state_d = ST_STOP_DIV;
      ST_STOP_DIV: if (!run_q && !oe_s_q) state_d = ST_STOP_REF;
      ST_STOP_REF: if (!ref_on_q) state_d = ST_OFF;
      ST_OFF:      if (!pd_req) state_d = ST_RUN;
      default:     state_d = ST_BOOT;
    endcase
  end

  // State register.
  always_ff @(posedge CLK) begin
    if (RST) state_q <= ST_BOOT;
    else if (CE) state_q <= state_d;
  end

  // Active configuration: loaded from storage only at boot, then static.
  always_ff @(posedge CLK) begin
    if (RST) begin
      mode_q <= MODE_RST;
      div_q  <= DIV_RST;
    end else if (CE && state_q == ST_BOOT && !PROG_MODE_PIN) begin
      mode_q <= nv_mode_q;
      div_q  <= nv_div_q;
    end
  end

  // Serial load through the divided-output pin, MSB first, mode word first.
  always_ff @(posedge CLK) begin
    if (RST) shift_q <= SHIFT_RST;
    else if (CE && state_q == ST_PROG && SER_STROBE)
      shift_q <= {shift_q[SHIFT_W-2:0], DIV_IO_IN};
  end

  // Nonvolatile store survives RST; only the factory reset restores it.
  always_ff @(posedge CLK) begin
    if (NV_FACTORY_RST) begin
      nv_mode_q <= NV_MODE_DEF;
      nv_div_q  <= NV_DIV_DEF;
    end else if (CE && state_q == ST_PROG && WRITE_CMD) begin
      nv_mode_q <= shift_q[SHIFT_W-1:WORD_W];
      nv_div_q  <= shift_q[WORD_W-1:0];
    end
  end

  // Oscillator runs except in boot, power-down and programming mode.
  always_ff @(posedge CLK) begin
    if (RST) osc_cnt_q <= '0;
    else if (CE && osc_run) osc_cnt_q <= osc_cnt_q + OSC_ONE;
  end

  // Reference mux select and master clock level.
  always_ff @(posedge CLK) begin
    if (RST) begin
      sel_ext_q <= 1'b0;
      mclk_q    <= 1'b0;
    end else if (CE) begin
      if (sw_ok) sel_ext_q <= want_ext;
      mclk_q <= mclk_d;
    end
  end

  // Enable is sampled on master clock rising edges only.
  always_ff @(posedge CLK) begin
    if (RST) oe_s_q <= 1'b0;
    else if (CE && mclk_rise) oe_s_q <= OE_PIN & (state_q == ST_RUN);
  end

  // Run gate: set on the second master edge after enable, cleared at a low.
  always_ff @(posedge CLK) begin
    if (RST) run_q <= 1'b0;
    else if (CE) begin
      if (run_set) run_q <= 1'b1;
      else if (run_clr) run_q <= 1'b0;
    end
  end

  // Divider counter is held at zero while gated off, for fixed restart phase.
  always_ff @(posedge CLK) begin
    if (RST) cnt_q <= CNT_ZERO;
    else if (CE) begin
      if (!run_q) cnt_q <= CNT_ZERO;
      else if (mclk_rise) cnt_q <= cnt_wrap ? CNT_ZERO : cnt_q + CNT_ONE;
    end
  end

  // Reference output gate.
  always_ff @(posedge CLK) begin
    if (RST) ref_on_q <= 1'b0;
    else if (CE) ref_on_q <= ref_gate;
  end

  // Pin registers; enables drop in power-down, boot and programming.
  always_ff @(posedge CLK) begin
    if (RST) begin
      div_pin_q <= 1'b0;
      div_oe_q  <= 1'b0;
      ref_pin_q <= 1'b0;
      ref_oe_q  <= 1'b0;
      buf_q     <= 1'b0;
    end else if (CE) begin
      div_pin_q <= run_q & div_raw;
      div_oe_q  <= outs_live;
      ref_pin_q <= ref_gate & mclk_d;
      ref_oe_q  <= outs_live & ~ref_dis;
      buf_q     <= outs_live;
    end
  end

  assign DIV_IO_OUT          = div_pin_q;
  assign DIV_IO_OE           = div_oe_q;
  assign REFERENCE_CLOCK_OUT = ref_pin_q;
  assign REFERENCE_CLOCK_OE  = ref_oe_q;
  assign BUFFERS_ON          = buf_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST || !CE);

  // Divided output gating and restart.
  no_truncate_a: assert property ($fell(run_q) |-> $past(!div_raw))
    else $error("Divided output gate closed while output high.");
  cnt_held_a: assert property (!run_q && CE |=> cnt_q == CNT_ZERO)
    else $error("Divider counter not held while disabled.");
  restart_edge_a: assert property ($rose(run_q) |=> DIV_IO_OUT)
    else $error("No output pulse right after restart.");
  div_low_a: assert property (!run_q |=> !DIV_IO_OUT)
    else $error("Divided output high while gated off.");
  div_byp_a: assert property (div_byp && run_q |=> DIV_IO_OUT == $past(mclk_q))
    else $error("Bypassed output does not follow the master clock.");

  // Power-down sequence and high impedance.
  pd_order_a: assert property (state_q == ST_STOP_REF |-> !run_q && osc_run)
    else $error("Reference stopped before divided output.");
  pd_req_a: assert property (state_q == ST_RUN && pd_req |=> state_q == ST_STOP_DIV)
    else $error("Power-down request did not start the stop sequence.");
  pd_osc_a: assert property (state_q == ST_OFF |=> $stable(osc_cnt_q))
    else $error("Oscillator still running in power-down.");
  pd_hiz_a: assert property (state_q == ST_OFF |=> !DIV_IO_OE && !REFERENCE_CLOCK_OE)
    else $error("Outputs driven during power-down.");
  buf_off_a: assert property (!outs_live |=> !BUFFERS_ON)
    else $error("Buffers powered while outputs are off.");
  prog_hiz_a: assert property (state_q == ST_PROG |=> !DIV_IO_OE && !REFERENCE_CLOCK_OE)
    else $error("Pins driven in programming mode.");

  // Reference output, source select and prescaler taps.
  ref_off_a: assert property (ref_dis |=> !REFERENCE_CLOCK_OE && !REFERENCE_CLOCK_OUT)
    else $error("Reference output active while disabled.");
  ref_oe_a: assert property (outs_live && !ref_dis |=> REFERENCE_CLOCK_OE)
    else $error("Reference output dropped while it should run.");
  sel_pin_a: assert property (!pin_fn && sw_ok |=>
      sel_ext_q == $past(!POWERDOWN_SELECT_PIN))
    else $error("Select pin did not steer the reference mux.");
  pre_skip_a: assert property ((pre_byp || div_byp) && !sel_ext_q |->
      mclk_d == osc_cnt_q[OSC_RAW_BIT])
    else $error("Prescaler not skipped in bypass.");
  pre_ratio_a: assert property (!pre_byp && !div_byp && !sel_ext_q |->
      mclk_d == (pre_ratio ? osc_cnt_q[OSC_DIV2_BIT] : osc_cnt_q[OSC_DIV4_BIT]))
    else $error("Prescaler ratio tap wrong.");

  // Divider count and configuration.
  div_wrap_a: assert property (run_q && mclk_rise && cnt_wrap |=> cnt_q == CNT_ZERO)
    else $error("Divider did not wrap at divisor minus one.");
  cfg_static_a: assert property (state_q != ST_BOOT |=> $stable(mode_q) && $stable(div_q))
    else $error("Configuration changed while running.");
  boot_load_a: assert property (state_q == ST_BOOT && !PROG_MODE_PIN |=>
      mode_q == $past(nv_mode_q) && div_q == $past(nv_div_q))
    else $error("Stored words not loaded at operating power-up.");

  // Main scenarios that the bench is expected to reach.
  cover_pd_c:      cover property (state_q == ST_STOP_DIV ##[1:200] state_q == ST_OFF);
  cover_restart_c: cover property ($fell(run_q) ##[1:200] $rose(run_q));
  cover_switch_c:  cover property (sw_ok && !pin_fn);
  cover_bypass_c:  cover property (div_byp && $rose(DIV_IO_OUT));
  cover_prog_c:    cover property (state_q == ST_PROG && SER_STROBE);

endmodule : pcd_top
`default_nettype wire

// ===== tb/pcd_board_ref.sv
// Board-side external reference clock that feeds the clock divider.
`timescale 1ns/100ps
`default_nettype none
module pcd_board_ref (
  input  wire logic clk,
  input  wire logic rst,
  output logic      ref_clk
);
  // ----------------------------------------------------------------
  // Reference generator
  // ----------------------------------------------------------------
  // Half period of five system clocks, so a ten-cycle reference is
  // easy to tell apart from every internal prescaler tap.
  logic [2:0] cnt_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q   <= 3'h0;
      ref_clk <= 1'b0;
    end else if (cnt_q == 3'h4) begin
      cnt_q   <= 3'h0;
      ref_clk <= ~ref_clk;
    end else begin
      cnt_q <= cnt_q + 3'h1;
    end
  end
endmodule : pcd_board_ref
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking testbench for the programmable clock divider.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk, rst, oe, pd_sel, ext_ref, prog, ser_in, strobe, wr, nv_rst;
  logic div_out, div_oe, ref_out, ref_oe, buf_on;
  int   error_cnt;
  int   comparisons;

  pcd_top DUT (.CLK(clk), .RST(rst), .CE(1'b1), .OE_PIN(oe), .POWERDOWN_SELECT_PIN(pd_sel),
    .EXT_REF_INPUT(ext_ref), .PROG_MODE_PIN(prog), .DIV_IO_IN(ser_in), .SER_STROBE(strobe),
    .WRITE_CMD(wr), .NV_FACTORY_RST(nv_rst), .DIV_IO_OUT(div_out), .DIV_IO_OE(div_oe),
    .REFERENCE_CLOCK_OUT(ref_out), .REFERENCE_CLOCK_OE(ref_oe), .BUFFERS_ON(buf_on));
  pcd_board_ref board (.clk(clk), .rst(rst), .ref_clk(ext_ref));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  // Case inequality keeps an unknown from passing as a match.
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic boot(input logic pmode);
    rst = 1'b1;
    prog = pmode;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
  endtask : boot

  // Shifts both words MSB first, stores them, then restarts in operating mode.
  task automatic program_cfg(input logic [8:0] mode, input logic [8:0] dv);
    logic [17:0] bits;
    bits = {mode, dv};
    boot(1'b1);
    for (int i = 17; i >= 0; i--) begin
      ser_in = bits[i];
      strobe = 1'b1;
      @(negedge clk);
    end
    strobe = 1'b0;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    boot(1'b0);
  endtask : program_cfg

  // Returns the number of falling edges until the divided output is seen rising.
  task automatic wait_rise(input int lim, output int n);
    logic p;
    n = 0;
    do begin
      p = div_out;
      @(negedge clk);
      n++;
    end while (!(p === 1'b0 && div_out === 1'b1) && n < lim);
  endtask : wait_rise

  task automatic div_period(input string what, input int exp);
    int n;
    wait_rise(300, n);
    wait_rise(300, n);
    check(what, 16'(exp), 16'(n));
  endtask : div_period

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Every prescaler, divider and source mode; strobes while running must not take.
  task automatic scn_modes();
    logic [8:0] md [7] = '{9'h000, 9'h008, 9'h004, 9'h002, 9'h011, 9'h013, 9'h024};
    logic [8:0] dv [7] = '{9'h000, 9'h001, 9'h002, 9'h1FF, 9'h000, 9'h005, 9'h000};
    int         per [7] = '{16, 12, 8, 2, 20, 10, 4};
    for (int k = 0; k < 7; k++) begin
      program_cfg(md[k], dv[k]);
      strobe = 1'b1;
      wr = 1'b1;
      repeat (3) @(negedge clk);
      strobe = 1'b0;
      wr = 1'b0;
      div_period("divided period", per[k]);
      check("divided drive", 16'h1, 16'(div_oe));
      check("reference drive", 16'(k != 6), 16'(ref_oe));
      check("buffers on", 16'h1, 16'(buf_on));
    end
  endtask : scn_modes

  // Enable dropped mid-pulse, held low, then released.
  task automatic scn_gate();
    int   n;
    int   hi;
    int   rises;
    logic p;
    logic stray;
    program_cfg(9'h000, 9'h001);
    wait_rise(300, n);
    repeat (3) @(negedge clk);
    oe = 1'b0;
    hi = 3;
    while (div_out === 1'b1 && hi < 100) begin
      @(negedge clk);
      hi++;
    end
    check("high pulse width", 16'd8, 16'(hi));
    rises = 0;
    stray = 1'b0;
    p = ref_out;
    repeat (60) begin
      @(negedge clk);
      if (div_out !== 1'b0) stray = 1'b1;
      if (p === 1'b0 && ref_out === 1'b1) rises++;
      p = ref_out;
    end
    check("held low while disabled", 16'h0, 16'(stray));
    check("reference keeps running", 16'h1, 16'(rises >= 7 && rises <= 8));
    oe = 1'b1;
    wait_rise(40, n);
    check("restart delay in range", 16'h1, 16'(n >= 8 && n <= 18));
  endtask : scn_gate

  // Power-down pin low tri-states both outputs; high brings them back.
  task automatic scn_powerdown();
    program_cfg(9'h010, 9'h000);
    pd_sel = 1'b0;
    repeat (60) @(negedge clk);
    check("divided drive off", 16'h0, 16'(div_oe));
    check("reference drive off", 16'h0, 16'(ref_oe));
    check("buffers off", 16'h0, 16'(buf_on));
    pd_sel = 1'b1;
    repeat (4) @(negedge clk);
    check("buffers back on", 16'h1, 16'(buf_on));
    div_period("period after wake", 16);
  endtask : scn_powerdown

  // Select mode: the pin overrides the source bit, switchable while running.
  task automatic scn_select();
    program_cfg(9'h001, 9'h000);
    div_period("pin high internal", 16);
    pd_sel = 1'b0;
    repeat (40) @(negedge clk);
    div_period("pin low external", 20);
    pd_sel = 1'b1;
    repeat (40) @(negedge clk);
    div_period("pin high again", 16);
  endtask : scn_select

  // ----------------------------------------------------------------
  // Clock, sequence and verdict
  // ----------------------------------------------------------------
  task automatic complete_run();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // The store is unknown until the factory reset, so it is pulsed with the first reset.
  initial begin
    {rst, nv_rst, oe, pd_sel} = 4'hF;
    {prog, ser_in, strobe, wr} = 4'h0;
    error_cnt = 0;
    comparisons = 0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    nv_rst = 1'b0;
    @(negedge clk);
    scn_modes();
    scn_gate();
    scn_powerdown();
    scn_select();
    complete_run();
  end

  // Whole run needs about a thousand cycles; this allows about eighty thousand.
  initial begin
    #2000000;
    error_cnt++;
    complete_run();
  end
endmodule : testbench
`default_nettype wire
